// ### pcs_config_status_vectors.sv
`timescale 1ns/1ps
`default_nettype none

module pcs_config_status_vectors
  import pcv_pkg::*;
#(
  parameter bit AN_PRESENT = 1'b1
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic [CTL_W-1:0]  controlVector,
  input  wire logic [VEC_W-1:0]  advertisement_settings_bus,
  input  wire logic              sgmiiMode,
  input  wire logic              macSide,
  input  wire logic [VEC_W-1:0]  partnerAbility,
  input  wire pcv_rx_ind_type    rxInd,
  output logic                   isolateClient,
  output logic                   anEnabled,
  output logic      [VEC_W-1:0]  advertisement_word,
  output logic      [STAT_W-1:0] statusVector
);

  typedef struct packed {
    logic [CTL_W-1:0]  ctl;
    logic [VEC_W-1:0]  adv;
    logic [STAT_W-1:0] stat;
  } pcv_state_type;

  pcv_state_type state_q;
  pcv_state_type state_d;
  pcv_mode_type  mode;
  logic [VEC_W-1:0] mappedWord;
  logic          anOn;
  logic          syncUp;
  logic          linkUp;

  always_comb begin
    if (!sgmiiMode) begin
      mode = PCV_BASEX;
    end else if (macSide) begin
      mode = PCV_SGMII_MAC;
    end else begin
      mode = PCV_SGMII_PHY;
    end
  end

  pcv_adv_map u_adv_map (
    .mode        (mode),
    .settingsBus (advertisement_settings_bus),
    .wordOut     (mappedWord)
  );

  always_comb begin
    state_d = state_q;
    // Control bits are loaded straight from the vector each cycle
    anOn   = AN_PRESENT && controlVector[CTL_AN_ENABLE];
    state_d.ctl = controlVector;
    // Stored enable is already masked by the build option
    state_d.ctl[CTL_AN_ENABLE] = anOn;
    // Advertisement word tracks the vector or the fixed MAC word
    state_d.adv = mappedWord;

    syncUp = rxInd.syncOk;
    // Link needs sync, finished negotiation when active, and transceiver ready
    linkUp = syncUp && rxInd.xcvrResetDone
             && (!anOn || rxInd.anComplete);

    state_d.stat = STAT_RESET;
    state_d.stat[ST_LINK]      = linkUp;
    state_d.stat[ST_SYNC]      = syncUp;
    state_d.stat[ST_CFG_SETS]  = rxInd.configSetsSeen;
    state_d.stat[ST_IDLE_SETS] = rxInd.idleSetsSeen;
    state_d.stat[ST_BAD_SET]   = rxInd.badSetSeen;
    state_d.stat[ST_DISP]      = rxInd.disparityFault;
    state_d.stat[ST_NOTABLE]   = rxInd.unknownCodeGroup;
    unique case (mode)
      PCV_SGMII_MAC: begin
        state_d.stat[ST_PHY_LINK] = partnerAbility[ADV_PHY_LINK]
                                    && rxInd.anComplete;
      end
      PCV_SGMII_PHY: begin
        state_d.stat[ST_PHY_LINK] = mappedWord[ADV_PHY_LINK]
                                    && rxInd.anComplete;
      end
      PCV_BASEX: begin
        state_d.stat[ST_PHY_LINK] = 1'b0;
      end
      default: begin
        state_d.stat[ST_PHY_LINK] = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= '{ctl: CTL_RESET, adv: ADV_RESET, stat: STAT_RESET};
    end else begin
      state_q <= state_d;
    end
  end

  always_comb begin
    isolateClient      = state_q.ctl[CTL_ISOLATE];
    anEnabled          = state_q.ctl[CTL_AN_ENABLE];
    advertisement_word = state_q.adv;
    statusVector       = state_q.stat;
  end

endmodule

`default_nettype wire

// ### pcv_pkg.sv
package pcv_pkg;

  localparam int VEC_W         = 16;
  localparam int CTL_W         = 5;
  localparam int STAT_W        = 8;

  // Control vector fields
  localparam int CTL_ISOLATE   = 3;
  localparam int CTL_AN_ENABLE = 4;

  // Advertisement vector fields
  localparam int ADV_SGMII_ONE = 0;
  localparam int ADV_FULL_DUP  = 5;
  localparam int ADV_PAUSE_LO  = 7;
  localparam int ADV_PAUSE_HI  = 8;
  localparam int ADV_SPEED_LO  = 10;
  localparam int ADV_SPEED_HI  = 11;
  localparam int ADV_RFLT_LO   = 12;
  localparam int ADV_RFLT_HI   = 13;
  localparam int ADV_SG_DUPLEX = 12;
  localparam int ADV_ACK       = 14;
  localparam int ADV_PHY_LINK  = 15;

  // Fixed word used when the SGMII end is on the MAC side, facing a PHY
  localparam logic [15:0] ADV_MAC_FIXED = 16'h4001;
  localparam logic [15:0] ADV_RESET     = 16'h0000;
  localparam logic [4:0]  CTL_RESET     = 5'h00;
  localparam logic [7:0]  STAT_RESET    = 8'h00;

  // Status vector fields
  localparam int ST_LINK       = 0;
  localparam int ST_SYNC       = 1;
  localparam int ST_CFG_SETS   = 2;
  localparam int ST_IDLE_SETS  = 3;
  localparam int ST_BAD_SET    = 4;
  localparam int ST_DISP       = 5;
  localparam int ST_NOTABLE    = 6;
  localparam int ST_PHY_LINK   = 7;

  typedef enum logic [1:0] {
    PCV_BASEX,
    PCV_SGMII_PHY,
    PCV_SGMII_MAC
  } pcv_mode_type;

  // Live indications from the receive path, all in the core clock domain
  typedef struct packed {
    logic syncOk;
    logic anComplete;
    logic xcvrResetDone;
    logic configSetsSeen;
    logic idleSetsSeen;
    logic badSetSeen;
    logic disparityFault;
    logic unknownCodeGroup;
  } pcv_rx_ind_type;

endpackage

// ### pcv_adv_map.sv
`timescale 1ns/1ps
`default_nettype none

module pcv_adv_map
  import pcv_pkg::*;
(
  input  wire pcv_mode_type      mode,
  input  wire logic [VEC_W-1:0]  settingsBus,
  output logic      [VEC_W-1:0]  wordOut
);

  always_comb begin
    wordOut = '0;
    unique case (mode)
      PCV_BASEX: begin
        wordOut[ADV_FULL_DUP]                = settingsBus[ADV_FULL_DUP];
        wordOut[ADV_PAUSE_HI:ADV_PAUSE_LO]   = settingsBus[ADV_PAUSE_HI:ADV_PAUSE_LO];
        wordOut[ADV_RFLT_HI:ADV_RFLT_LO]     = settingsBus[ADV_RFLT_HI:ADV_RFLT_LO];
      end
      PCV_SGMII_PHY: begin
        wordOut[ADV_SGMII_ONE]               = 1'b1;
        wordOut[ADV_SPEED_HI:ADV_SPEED_LO]   = settingsBus[ADV_SPEED_HI:ADV_SPEED_LO];
        wordOut[ADV_SG_DUPLEX]               = settingsBus[ADV_SG_DUPLEX];
        wordOut[ADV_ACK]                     = settingsBus[ADV_ACK];
        wordOut[ADV_PHY_LINK]                = settingsBus[ADV_PHY_LINK];
      end
      PCV_SGMII_MAC: begin
        wordOut = ADV_MAC_FIXED;
      end
      default: begin
        wordOut = '0;
      end
    endcase
  end

endmodule

`default_nettype wire

// ### pcv_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pcv_chk
  import pcv_pkg::*;
#(
  parameter bit AN_PRESENT = 1'b1
) (
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic [CTL_W-1:0]  controlVector,
  input wire logic [VEC_W-1:0]  advertisement_settings_bus,
  input wire logic              sgmiiMode,
  input wire logic              macSide,
  input wire logic [VEC_W-1:0]  partnerAbility,
  input wire pcv_rx_ind_type    rxInd,
  input wire logic              isolateClient,
  input wire logic              anEnabled,
  input wire logic [VEC_W-1:0]  advertisement_word,
  input wire logic [STAT_W-1:0] statusVector
);
  wire logic       anOn = AN_PRESENT & controlVector[CTL_AN_ENABLE];
  wire logic       linkOk = rxInd.syncOk & rxInd.xcvrResetDone & (!anOn | rxInd.anComplete);
  wire logic [4:0] flags = {<<{rxInd[4:0]}};
  wire logic       phyBit = macSide ? partnerAbility[15] : advertisement_settings_bus[15];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_live; !rst; endsequence
  sequence s_basex; !rst && !sgmiiMode; endsequence
  chk_isolate_copy:
    assert property (s_live |=> isolateClient == $past(controlVector[CTL_ISOLATE])) else $error("isolate");
  chk_an_enable:
    assert property (s_live |=> anEnabled == $past(anOn)) else $error("an enable");
  chk_mac_fixed:
    assert property (s_live ##0 sgmiiMode && macSide |=> advertisement_word == 16'h4001) else $error("mac adv");
  chk_basex_map:
    assert property (s_basex |=> advertisement_word == ($past(advertisement_settings_bus) & 16'h31A0)) else $error("basex adv");
  chk_phy_map:
    assert property (s_live ##0 sgmiiMode && !macSide |=> advertisement_word == ($past(advertisement_settings_bus) & 16'hDC00 | 16'h0001)) else $error("phy adv");
  chk_link_status:
    assert property (s_live |=> statusVector[0] == $past(linkOk)) else $error("link");
  chk_sync_live:
    assert property (s_live |=> statusVector[1] == $past(rxInd.syncOk)) else $error("sync");
  chk_live_flags:
    assert property (s_live |=> statusVector[6:2] == $past(flags)) else $error("flags");
  chk_phy_link:
    assert property (s_live ##0 sgmiiMode |=> statusVector[7] == ($past(phyBit) & $past(rxInd.anComplete))) else $error("phy link");
  chk_basex_low:
    assert property (s_basex |=> !statusVector[7]) else $error("bit7");
endmodule
bind pcs_config_status_vectors pcv_chk #(.AN_PRESENT(AN_PRESENT)) chk_u (.*);
`default_nettype wire

// ### pcv_user_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcv_user_model
  import pcv_pkg::*;
(
  input wire logic          clk,
  output logic [CTL_W-1:0]  ctl,
  output logic [VEC_W-1:0]  adv,
  output logic              sg,
  output logic              mac,
  output logic [VEC_W-1:0]  lp,
  output pcv_rx_ind_type    ind
);
  initial {ctl, adv, sg, mac, lp, ind} = '0;
  // Fresh settings and receive levels every cycle, off the sampling edge
  always @(negedge clk) begin
    {ctl, sg, mac} <= 7'($urandom);
    adv <= 16'($urandom);
    lp <= 16'($urandom);
    ind <= pcv_rx_ind_type'(8'($urandom));
  end
endmodule
`default_nettype wire

// ### pcs_config_status_vectors_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pcs_config_status_vectors_tb_top
  import pcv_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [CTL_W-1:0] ctl;
  logic [VEC_W-1:0] adv, lp, advOut, expAdv;
  logic sg, mac, iso, anEn;
  pcv_rx_ind_type ind;
  logic [STAT_W-1:0] st, expSt;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  always #2 core_clk = ~core_clk;
  pcv_user_model user_u (.clk(core_clk), .ctl(ctl), .adv(adv), .sg(sg), .mac(mac), .lp(lp), .ind(ind));
  pcs_config_status_vectors dut_u (.core_clk(core_clk), .rst(rst), .controlVector(ctl),
    .advertisement_settings_bus(adv), .sgmiiMode(sg), .macSide(mac), .partnerAbility(lp),
    .rxInd(ind), .isolateClient(iso), .anEnabled(anEn), .advertisement_word(advOut),
    .statusVector(st));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Reference: outputs after an edge reflect the inputs held across that edge
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      test_done();
    end
    #1;
    if (!sg) expAdv = adv & 16'h31A0;
    else if (mac) expAdv = 16'h4001;
    else expAdv = adv & 16'hDC00 | 16'h0001;
    expSt[0] = ind.syncOk & ind.xcvrResetDone & (!ctl[CTL_AN_ENABLE] | ind.anComplete);
    expSt[1] = ind.syncOk;
    expSt[6:2] = {ind.unknownCodeGroup, ind.disparityFault, ind.badSetSeen,
                  ind.idleSetsSeen, ind.configSetsSeen};
    expSt[7] = sg & ind.anComplete & (mac ? lp[15] : adv[15]);
    if (rst) {expAdv, expSt} = '0;
    check(16'(iso), 16'(ctl[CTL_ISOLATE] & !rst));
    check(16'(anEn), 16'(ctl[CTL_AN_ENABLE] & !rst));
    check(advOut, expAdv);
    check(16'(st), 16'(expSt));
  end
  initial begin
    void'($urandom(62680));
    repeat (2) @(negedge core_clk);
    rst <= 1'b0;
    repeat (2000) @(negedge core_clk);
    test_done();
  end
endmodule
`default_nettype wire
